// file: logic/sector_protect_map_access.sv
// Command logic for the nonvolatile sector protection map.
//
// Overview of operation
// - Sixteen-byte protection map; byte n selects guarding of sector n.
// - Byte FFH marks sector protected, 00H unprotected; FFH is erased value.
// - Sector 0 byte: bits 7,6 pages 0-7, bits 5,4 pages 8-255.
// - Erase command is opcodes 3DH 2AH 7FH CFH after select falls.
// - Select release after erase opcodes starts timed erase, busy throughout.
// - Map erase and program accepted whether protection is on or off.
// - Protection on with map all FFH refuses every main-array change.
// - Program command is 3DH 2AH 7FH FCH followed by map data bytes.
// - Select release after data starts timed program, busy throughout.
// - More than sixteen data bytes wrap the pointer back to location zero.
// - Early select release leaves unsent sectors undefined.
// - Map reprogramming accepted while protection stays enabled.
// - Program command uses data buffer 1 as working storage, overwriting it.
// - Read is 32H plus three dummy bytes, then map bytes out in order.
// - After sixteen bytes out, further clocks give undefined data.
// - Select release ends the read and floats the serial output.
// - Map holds 00H in every byte from the factory.
// - Write guard asserted refuses map changes and guards marked sectors.
`timescale 1ns/1ps
`include "sector_guard_cfg.svh"
module sector_protect_map_access #(
	parameter int ERASE_TIME_NS = `MAP_ERASE_TIME_NS,
	parameter int PROGRAM_TIME_NS = `MAP_PROGRAM_TIME_NS,
	parameter int MAP_BYTES = `MAP_BYTES
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic select_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	input wire logic prot_enabled_in,
	input wire logic write_guard_n_in,
	output logic busy_out,
	output logic [MAP_BYTES-1:0] sector_guarded_out,
	output logic sector0_low_part_out,
	output logic sector0_high_part_out,
	output logic main_array_locked_out,
	output logic buf1_wr_en_out,
	output logic [3:0] buf1_wr_addr_out,
	output logic [7:0] buf1_wr_data_out
);

	localparam int ERASE_CYCLES = ERASE_TIME_NS / `CLK_PERIOD_NS;
	localparam int PROGRAM_CYCLES = PROGRAM_TIME_NS / `CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Serial front end.

	logic sclk_rise;
	logic sclk_fall;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [2:0] bit_count;

	serial_byte_shifter shifter (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.select_n_in(select_n_in),
		.sclk_in(sclk_in),
		.sdi_in(sdi_in),
		.sclk_rise_out(sclk_rise),
		.sclk_fall_out(sclk_fall),
		.byte_done_out(byte_done),
		.byte_out(rx_byte),
		.bit_count_out(bit_count)
	);

	////////////////////////////////////////////////////////////////////////
	// State and storage.

	sector_guard_pkg::map_state_t state_reg;
	sector_guard_pkg::map_state_t state_next;
	sector_guard_pkg::cmd_kind_t kind_reg;
	sector_guard_pkg::cmd_kind_t kind_next;
	logic select_prev_reg;
	logic [7:0] byte_cnt_reg;
	logic [3:0] data_ptr_reg;
	logic [31:0] timer_reg;
	logic sdo_reg;
	logic buf1_wr_en_reg;
	logic [3:0] buf1_wr_addr_reg;
	logic [7:0] buf1_wr_data_reg;
	logic [7:0] map_reg [MAP_BYTES];
	logic [7:0] buf1_reg [MAP_BYTES];
	logic [MAP_BYTES-1:0] byte_erased;
	logic byte_ok;

	////////////////////////////////////////////////////////////////////////
	// Decode.

	wire in_cmd = (state_reg == sector_guard_pkg::ST_CMD);
	wire sel_fall = select_prev_reg && !select_n_in;
	wire sel_release = in_cmd && select_n_in;
	wire on_boundary = (bit_count == 3'h0);
	wire header_done = (byte_cnt_reg >= `OPC_HEADER_BYTES);
	wire is_read = (kind_reg == sector_guard_pkg::KIND_READ);
	wire is_prog = (kind_reg == sector_guard_pkg::KIND_PROG);
	wire data_byte = in_cmd && byte_done && is_prog && header_done;
	wire [7:0] read_idx = byte_cnt_reg - `OPC_HEADER_BYTES;
	wire read_in_range = (read_idx < 8'(MAP_BYTES));
	wire [7:0] read_byte = map_reg[read_idx[3:0]];
	wire [2:0] out_bit = 3'h7 - bit_count;
	wire erase_ok = (kind_reg == sector_guard_pkg::KIND_ERASE) &&
		(byte_cnt_reg == `OPC_HEADER_BYTES) && write_guard_n_in;
	wire prog_ok = is_prog && write_guard_n_in;
	// only whole bytes start a cycle
	wire start_erase = sel_release && on_boundary && erase_ok;
	wire start_prog = sel_release && on_boundary && prog_ok;
	wire timer_zero = (timer_reg == 32'h0);
	wire erase_done = (state_reg == sector_guard_pkg::ST_ERASE) && timer_zero;
	wire prog_done = (state_reg == sector_guard_pkg::ST_PROG) && timer_zero;
	wire prot_on = prot_enabled_in || !write_guard_n_in;

	assign busy_out = (state_reg == sector_guard_pkg::ST_ERASE) ||
		(state_reg == sector_guard_pkg::ST_PROG);
	assign sdo_oe_out = in_cmd && is_read && header_done && !select_n_in;
	assign sdo_out = sdo_reg;
	assign buf1_wr_en_out = buf1_wr_en_reg;
	assign buf1_wr_addr_out = buf1_wr_addr_reg;
	assign buf1_wr_data_out = buf1_wr_data_reg;
	// sector 0 split into two parts
	assign sector0_low_part_out = prot_on &&
		(&map_reg[0][`S0_LOW_PART_MSB:`S0_LOW_PART_LSB]);
	assign sector0_high_part_out = prot_on &&
		(&map_reg[0][`S0_HIGH_PART_MSB:`S0_HIGH_PART_LSB]);
	assign main_array_locked_out = prot_on && (&byte_erased);

	always_comb begin
		kind_next = kind_reg;
		byte_ok = 1'b1;
		case (byte_cnt_reg)
			8'h00: begin
				if (rx_byte == `OPC_PREFIX_0) begin
					kind_next = sector_guard_pkg::KIND_PREFIX;
				end else if (rx_byte == `OPC_MAP_READ) begin
					kind_next = sector_guard_pkg::KIND_READ;
				end else begin
					byte_ok = 1'b0;
				end
			end
			8'h01: begin
				byte_ok = is_read || (rx_byte == `OPC_PREFIX_1);
			end
			8'h02: begin
				byte_ok = is_read || (rx_byte == `OPC_PREFIX_2);
			end
			8'h03: begin
				if (is_read) begin
					byte_ok = 1'b1;
				end else if (rx_byte == `OPC_MAP_ERASE) begin
					kind_next = sector_guard_pkg::KIND_ERASE;
				end else if (rx_byte == `OPC_MAP_PROGRAM) begin
					kind_next = sector_guard_pkg::KIND_PROG;
				end else begin
					byte_ok = 1'b0;
				end
			end
			default: begin
				byte_ok = is_read || is_prog;
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sector_guard_pkg::ST_IDLE: begin
				if (sel_fall) begin
					state_next = sector_guard_pkg::ST_CMD;
				end
			end
			sector_guard_pkg::ST_CMD: begin
				if (start_erase) begin
					state_next = sector_guard_pkg::ST_ERASE;
				end else if (start_prog) begin
					state_next = sector_guard_pkg::ST_PROG;
				end else if (select_n_in) begin
					state_next = sector_guard_pkg::ST_IDLE;
				end else if (byte_done && !byte_ok) begin
					state_next = sector_guard_pkg::ST_IGNORE;
				end
			end
			sector_guard_pkg::ST_IGNORE: begin
				if (select_n_in) begin
					state_next = sector_guard_pkg::ST_IDLE;
				end
			end
			sector_guard_pkg::ST_ERASE,
			sector_guard_pkg::ST_PROG: begin
				if (timer_zero) begin
					state_next = sector_guard_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = sector_guard_pkg::ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencing.

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_reg <= sector_guard_pkg::ST_IDLE;
			select_prev_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			select_prev_reg <= select_n_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in || sel_fall) begin
			kind_reg <= sector_guard_pkg::KIND_NONE;
			byte_cnt_reg <= 8'h00;
		end else if (in_cmd && byte_done) begin
			kind_reg <= kind_next;
			if (byte_cnt_reg != 8'hff) begin
				byte_cnt_reg <= byte_cnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in || sel_fall) begin
			data_ptr_reg <= 4'h0;
		end else if (data_byte) begin
			data_ptr_reg <= data_ptr_reg + 4'h1;
		end
	end

	// data bytes go to buffer 1
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			buf1_wr_en_reg <= 1'b0;
			buf1_wr_addr_reg <= 4'h0;
			buf1_wr_data_reg <= 8'h00;
		end else begin
			buf1_wr_en_reg <= data_byte;
			if (data_byte) begin
				buf1_wr_addr_reg <= data_ptr_reg;
				buf1_wr_data_reg <= rx_byte;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			timer_reg <= 32'h0;
		end else if (start_erase) begin
			timer_reg <= 32'(ERASE_CYCLES - 1);
		end else if (start_prog) begin
			timer_reg <= 32'(PROGRAM_CYCLES - 1);
		end else if (!timer_zero) begin
			timer_reg <= timer_reg - 32'h1;
		end
	end

	// map bytes shifted out in order
	// beyond sixteen bytes zeros shift out
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			sdo_reg <= 1'b0;
		end else if (sclk_fall && in_cmd && is_read && header_done) begin
			sdo_reg <= read_in_range && read_byte[out_bit];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Map entries, one per sector.

	genvar i;
	generate
		for (i = 0; i < MAP_BYTES; i++) begin : g_entry
			assign byte_erased[i] = (map_reg[i] == `MAP_ERASED_VALUE);
			if (i == 0) begin : g_s0
				assign sector_guarded_out[i] =
					sector0_low_part_out && sector0_high_part_out;
			end else begin : g_sn
				assign sector_guarded_out[i] = prot_on && byte_erased[i];
			end
			always_ff @(posedge clock_in) begin
				if (data_byte && (data_ptr_reg == 4'(i))) begin
					buf1_reg[i] <= rx_byte;
				end
			end
			always_ff @(posedge clock_in) begin
				if (reset_in) begin
					map_reg[i] <= `MAP_FACTORY_VALUE;
				end else if (erase_done) begin
					map_reg[i] <= `MAP_ERASED_VALUE;
				end else if (prog_done) begin
					map_reg[i] <= map_reg[i] & buf1_reg[i];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Checks.

	AST_ERASE_START: assert property (
		@(posedge clock_in) disable iff (reset_in)
		start_erase |=> busy_out [*8])
		else $error("Erase did not hold busy after select release.");

	AST_PROG_START: assert property (
		@(posedge clock_in) disable iff (reset_in)
		start_prog |=> busy_out && $stable(map_reg[0]))
		else $error("Program did not raise busy.");

	AST_ERASE_FILL: assert property (
		@(posedge clock_in) disable iff (reset_in)
		erase_done |=> (&byte_erased) && !busy_out)
		else $error("Erase did not leave every byte erased.");

	AST_LOCK_AFTER_ERASE: assert property (
		@(posedge clock_in) disable iff (reset_in)
		erase_done && prot_enabled_in |=> main_array_locked_out)
		else $error("Array not locked with map erased.");

	AST_GUARD_BLOCKS: assert property (
		@(posedge clock_in) disable iff (reset_in)
		sel_release && !write_guard_n_in |=> !busy_out)
		else $error("Map changed while write guard asserted.");

	AST_OFF_BOUNDARY: assert property (
		@(posedge clock_in) disable iff (reset_in)
		sel_release && !on_boundary |=> !busy_out)
		else $error("Command started off a byte boundary.");

	AST_FLOAT_ON_RELEASE: assert property (
		@(posedge clock_in) disable iff (reset_in)
		select_n_in |-> !sdo_oe_out)
		else $error("Serial output driven with select released.");

	AST_BUF1_WRITE: assert property (
		@(posedge clock_in) disable iff (reset_in)
		data_byte |=> buf1_wr_en_out &&
			buf1_wr_addr_out == $past(data_ptr_reg))
		else $error("Data byte not written to buffer 1.");

	AST_WRAP: assert property (
		@(posedge clock_in) disable iff (reset_in)
		data_byte && data_ptr_reg == 4'hf |=> data_ptr_reg == 4'h0)
		else $error("Data pointer did not wrap to zero.");

	AST_FACTORY: assert property (
		@(posedge clock_in)
		reset_in |=> map_reg[0] == `MAP_FACTORY_VALUE && !busy_out)
		else $error("Map not at factory value after reset.");

endmodule

// file: logic/sector_guard_cfg.svh
// Constants for the sector protection map command logic.
`ifndef SECTOR_GUARD_CFG_SVH
`define SECTOR_GUARD_CFG_SVH

`define CLK_PERIOD_NS 20
`define MAP_ERASE_TIME_NS 1000000
`define MAP_PROGRAM_TIME_NS 500000

`define MAP_BYTES 16
`define MAP_FACTORY_VALUE 8'h00
`define MAP_ERASED_VALUE 8'hff

`define OPC_PREFIX_0 8'h3d
`define OPC_PREFIX_1 8'h2a
`define OPC_PREFIX_2 8'h7f
`define OPC_MAP_ERASE 8'hcf
`define OPC_MAP_PROGRAM 8'hfc
`define OPC_MAP_READ 8'h32
`define OPC_HEADER_BYTES 8'h04

`define S0_LOW_PART_MSB 7
`define S0_LOW_PART_LSB 6
`define S0_HIGH_PART_MSB 5
`define S0_HIGH_PART_LSB 4

`endif

// file: logic/sector_guard_pkg.sv
// Types shared by the sector protection map command logic.
package sector_guard_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_IGNORE,
		ST_ERASE,
		ST_PROG
	} map_state_t;

	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_PREFIX,
		KIND_ERASE,
		KIND_PROG,
		KIND_READ
	} cmd_kind_t;

endpackage

// file: logic/serial_byte_shifter.sv
// Serial input shifter: edge detect, bit count and byte assembly.
`timescale 1ns/1ps
module serial_byte_shifter (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic select_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	output logic sclk_rise_out,
	output logic sclk_fall_out,
	output logic byte_done_out,
	output logic [7:0] byte_out,
	output logic [2:0] bit_count_out
);

	logic sclk_prev_reg;
	logic [6:0] shift_reg;
	logic [2:0] bit_count_reg;
	logic byte_done_reg;
	logic [7:0] byte_reg;
	wire last_bit = sclk_rise_out && (bit_count_reg == 3'h7);

	assign sclk_rise_out = !select_n_in && sclk_in && !sclk_prev_reg;
	assign sclk_fall_out = !select_n_in && !sclk_in && sclk_prev_reg;
	assign byte_done_out = byte_done_reg;
	assign byte_out = byte_reg;
	assign bit_count_out = bit_count_reg;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			sclk_prev_reg <= 1'b0;
			shift_reg <= 7'h00;
			bit_count_reg <= 3'h0;
			byte_done_reg <= 1'b0;
			byte_reg <= 8'h00;
		end else begin
			sclk_prev_reg <= sclk_in;
			byte_done_reg <= last_bit;
			if (select_n_in) begin
				bit_count_reg <= 3'h0;
			end else if (sclk_rise_out) begin
				shift_reg <= {shift_reg[5:0], sdi_in};
				bit_count_reg <= bit_count_reg + 3'h1;
			end
			if (last_bit) begin
				byte_reg <= {shift_reg, sdi_in};
			end
		end
	end

endmodule

// file: tb/spi_host_model.sv
// Host serial controller model driving select, serial clock and data.
`timescale 1ns/1ps
module spi_host_model (
	input wire logic clock_in,
	input wire logic sdo_in,
	output logic select_n_out,
	output logic sclk_out,
	output logic sdi_out
);
	initial begin
		select_n_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clock_in);
	endtask

	////////////////////////////////////////////////////////////////////////
	// select opens frame
	task automatic open_frame();
		wait_cyc(1);
		select_n_out = 1'b0;
		wait_cyc(2);
	endtask

	task automatic xfer(input logic [7:0] tx, input int nbits,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nbits; i--) begin
			sclk_out = 1'b0;
			sdi_out = tx[i];
			wait_cyc(3);
			sclk_out = 1'b1;
			wait_cyc(2);
			rx[i] = sdo_in;
		end
	endtask

	// The released data line shows the inverse of its last level.
	task automatic close_frame();
		sclk_out = 1'b0;
		wait_cyc(2);
		select_n_out = 1'b1;
		sdi_out = ~sdi_out;
		wait_cyc(2);
	endtask
endmodule

// file: tb/tb_sector_protect_map_access.sv
// Self-checking bench for the sector protection map command logic.
`timescale 1ns/1ps
`include "sector_guard_cfg.svh"
module tb_sector_protect_map_access;
	localparam int ERASE_NS = 200;
	localparam int PROG_NS = 100;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic prot_enabled_in = 1'b0;
	logic write_guard_n_in = 1'b1;
	logic select_n, sclk, sdi, sdo_out, sdo_oe_out, busy_out;
	logic [15:0] sector_guarded_out;
	logic sector0_low_part_out, sector0_high_part_out, main_array_locked_out;
	logic buf1_wr_en_out;
	logic [3:0] buf1_wr_addr_out;
	logic [7:0] buf1_wr_data_out;
	int fail_count = 0;
	int check_count = 0;
	int busy_cycles = 0;
	logic sdo_line;
	logic [31:0] lfsr_reg = 32'hec26a097;
	logic [7:0] map_model [16];
	logic [7:0] rx;
	logic [11:0] wr_q [$];
	logic [7:0] s0_vals [2] = '{8'hc0, 8'h30};

	always #(`CLK_PERIOD_NS / 2) clock_in = ~clock_in;

	// A released serial output shows the inverse of its last level.
	assign sdo_line = sdo_oe_out ? sdo_out : ~sdo_out;

	always @(negedge clock_in) begin
		if (busy_out === 1'b1) begin
			busy_cycles++;
		end
		if (buf1_wr_en_out === 1'b1) begin
			wr_q.push_back({buf1_wr_addr_out, buf1_wr_data_out});
		end
	end

	spi_host_model host_u (
		.clock_in(clock_in),
		.sdo_in(sdo_line),
		.select_n_out(select_n),
		.sclk_out(sclk),
		.sdi_out(sdi)
	);

	sector_protect_map_access #(
		.ERASE_TIME_NS(ERASE_NS),
		.PROGRAM_TIME_NS(PROG_NS),
		.MAP_BYTES(16)
	) dut_u (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.select_n_in(select_n),
		.sclk_in(sclk),
		.sdi_in(sdi),
		.sdo_out(sdo_out),
		.sdo_oe_out(sdo_oe_out),
		.prot_enabled_in(prot_enabled_in),
		.write_guard_n_in(write_guard_n_in),
		.busy_out(busy_out),
		.sector_guarded_out(sector_guarded_out),
		.sector0_low_part_out(sector0_low_part_out),
		.sector0_high_part_out(sector0_high_part_out),
		.main_array_locked_out(main_array_locked_out),
		.buf1_wr_en_out(buf1_wr_en_out),
		.buf1_wr_addr_out(buf1_wr_addr_out),
		.buf1_wr_data_out(buf1_wr_data_out)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic check_guards();
		logic on;
		logic all_ff;
		on = prot_enabled_in | ~write_guard_n_in;
		all_ff = 1'b1;
		for (int n = 0; n < 16; n++) begin
			all_ff = all_ff & (map_model[n] == 8'hff);
		end
		for (int n = 1; n < 16; n++) begin
			check_flag(sector_guarded_out[n], on & (map_model[n] == 8'hff));
		end
		check_flag(sector0_low_part_out, on & (map_model[0][7:6] == 2'b11));
		check_flag(sector0_high_part_out, on & (map_model[0][5:4] == 2'b11));
		check_flag(sector_guarded_out[0], on & (map_model[0][7:4] == 4'hf));
		check_flag(main_array_locked_out, on & all_ff);
	endtask

	task automatic send_header(input logic [7:0] op, input int nbits);
		host_u.open_frame();
		host_u.xfer(`OPC_PREFIX_0, 8, rx);
		host_u.xfer(`OPC_PREFIX_1, 8, rx);
		host_u.xfer(`OPC_PREFIX_2, 8, rx);
		host_u.xfer(op, nbits, rx);
	endtask

	// Counts busy cycles seen after release; zero means refused.
	task automatic end_write(input int n);
		int cnt;
		int base;
		base = busy_cycles;
		host_u.close_frame();
		cnt = 0;
		while (busy_out === 1'b1 && cnt < 50) begin
			cnt++;
			@(negedge clock_in);
		end
		check_byte(8'(busy_cycles - base), 8'(n));
	endtask

	// Extra bits after the erase opcode leave the frame off a byte boundary.
	task automatic do_erase(input int extra, input bit ok);
		send_header(`OPC_MAP_ERASE, 8);
		if (extra > 0) begin
			host_u.xfer(8'h00, extra, rx);
		end
		end_write(ok ? ERASE_NS / `CLK_PERIOD_NS : 0);
		for (int n = 0; n < 16 && ok; n++) begin
			map_model[n] = 8'hff;
		end
	endtask

	task automatic do_program(input logic [7:0] b0, input int count);
		logic [7:0] d;
		logic [7:0] data_q [16];
		logic [11:0] exp_q [$];
		wr_q.delete();
		send_header(`OPC_MAP_PROGRAM, 8);
		for (int k = 0; k < count; k++) begin
			lfsr_reg = lfsr_step(lfsr_reg);
			d = (k == 0) ? b0 : {8{lfsr_reg[0]}};
			host_u.xfer(d, 8, rx);
			data_q[k % 16] = d;
			exp_q.push_back({4'(k % 16), d});
		end
		end_write(PROG_NS / `CLK_PERIOD_NS);
		for (int n = 0; n < 16; n++) begin
			map_model[n] = map_model[n] & data_q[n];
		end
		check_byte(8'(wr_q.size()), 8'(count));
		for (int k = 0; k < count && k < wr_q.size(); k++) begin
			check_byte({4'h0, wr_q[k][11:8]}, {4'h0, exp_q[k][11:8]});
			check_byte(wr_q[k][7:0], exp_q[k][7:0]);
		end
	endtask

	task automatic read_map();
		host_u.open_frame();
		host_u.xfer(`OPC_MAP_READ, 8, rx);
		for (int i = 0; i < 3; i++) begin
			lfsr_reg = lfsr_step(lfsr_reg);
			host_u.xfer(lfsr_reg[7:0], 8, rx);
		end
		check_flag(sdo_oe_out, 1'b1);
		for (int n = 0; n < 16; n++) begin
			host_u.xfer(8'h00, 8, rx);
			check_byte(rx, map_model[n]);
		end
		host_u.close_frame();
		check_flag(sdo_oe_out, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge clock_in);
		reset_in = 1'b0;
		for (int n = 0; n < 16; n++) begin
			map_model[n] = `MAP_FACTORY_VALUE;
		end
		check_guards();
		read_map();
		prot_enabled_in = 1'b1;
		do_erase(0, 1'b1);
		check_guards();
		read_map();
		do_program(8'hff, 17);
		check_guards();
		read_map();
		for (int i = 0; i < 2; i++) begin
			prot_enabled_in = 1'b0;
			do_erase(0, 1'b1);
			do_program(s0_vals[i], 16);
			prot_enabled_in = 1'b1;
			@(negedge clock_in);
			check_guards();
		end
		do_erase(5, 1'b0);
		write_guard_n_in = 1'b0;
		do_erase(0, 1'b0);
		check_guards();
		write_guard_n_in = 1'b1;
		read_map();
		print_verdict();
	end

	initial begin
		#1000000;
		fail_count++;
		print_verdict();
	end
endmodule
